// File: logic/lsr_ramp_ch2.sv
// Operation
// - Log mode ramps code between low and high margin, 3.125 percent steps.
// - Upward log step: next equals current times one plus 1/32.
// - Downward log step: next equals current times one minus 1/32.
// - Zero low margin: log ramp starts from code 1.
// - Rise interval times upward steps, fall interval times downward steps.
// - Rise select decodes 4 to 1282 microseconds per step.
// - Fall select decodes 4 to 1282 microseconds per step.
// - Waveform select: triangle, sawtooth, inverse sawtooth, sine, or disabled.
// - Log enable clear: linear slew stepping used instead.
`timescale 1ns/1ns
module lsr_ramp_ch2 #(
	parameter int CODE_W = 10,
	parameter int CLK_PERIOD_NS = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Configuration word access
	input wire logic cfg_wr,
	input wire lsr_pkg::lsr_cfg_t cfg_wdata,
	output lsr_pkg::lsr_cfg_t cfg_q,
	// Margin codes and margin pin
	input wire logic [CODE_W-1:0] margin_low,
	input wire logic [CODE_W-1:0] margin_high,
	input wire logic margin_high_pin,
	// Channel-2 output and status
	output logic [CODE_W-1:0] dac_code_q,
	output logic busy_q,
	output lsr_pkg::lsr_wave_t wave_q,
	output logic fgen_on_q
);
	import lsr_pkg::*;

	// ==========================================================
	// Declarations
	// ==========================================================
	logic sync1_q;
	logic sync2_q;
	logic [CODE_W-1:0] target;
	logic up;
	logic at_target;
	int step_ns;
	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] cnt_q;
	logic [3:0] lin_rate;
	logic lin_jump;
	logic step_now;
	logic [CODE_W:0] delta;
	logic [CODE_W:0] next_up;
	logic [CODE_W:0] next_dn;
	logic [CODE_W-1:0] code_d;

	// ==========================================================
	// Configuration word
	// ==========================================================
	// Whole word stored; spare bits read back as written
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_q <= lsr_cfg_t'(CFG_RESET);
		end else if (cfg_wr) begin
			cfg_q <= cfg_wdata;
		end
	end

	// Pin crosses in from outside, so two flops first
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= margin_high_pin;
			sync2_q <= sync1_q;
		end
	end

	// ==========================================================
	// Linear rate field
	// ==========================================================
	// Rate shares bits with fall select and the spare bit
	assign lin_rate = {cfg_q.fall_sel, cfg_q.lsb};

	// linear jump rate
	// Rate 0000 skips slewing; the code goes straight to the target
	assign lin_jump = !cfg_q.log_slew_en && lin_rate == LIN_NO_SLEW;

	// ==========================================================
	// Direction and step timing
	// ==========================================================
	// endpoints from margin codes
	assign target = sync2_q ? margin_high : margin_low;
	assign up = target > dac_code_q;
	assign at_target = target == dac_code_q;

	// Select step time by mode and direction
	always_comb begin
		if (cfg_q.log_slew_en) begin
			step_ns = up ? lsr_log_ns(cfg_q.rise_sel)
				: lsr_log_ns(cfg_q.fall_sel);
		end else begin
			step_ns = lsr_lin_ns(lin_rate);
		end
	end

	// Round up to whole cycles; never below one
	// Count width fits the slowest rate at clock periods of 5 ns and above
	assign period = CNT_W'((step_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Step when the interval runs out, or at once for a jump
	assign step_now = !at_target
		&& (lin_jump || cnt_q >= period - CNT_W'(1));

	// Interval counter restarts at each step and while idle
	// A target change mid-ramp keeps the count; redirect steps when that count runs out
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= '0;
		end else if (at_target || step_now) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// ==========================================================
	// Next code
	// ==========================================================
	always_comb begin
		if (cfg_q.log_slew_en) begin
			// geometric fraction, at least one LSB
			delta = (CODE_W+1)'(dac_code_q >> LOG_SHIFT);
			// Small codes give no fraction; one LSB keeps it moving
			if (delta == '0) begin
				delta = (CODE_W+1)'(1);
			end
		end else begin
			delta = (CODE_W+1)'(lsr_lin_step(cfg_q.rise_sel));
		end
	end

	assign next_up = {1'b0, dac_code_q} + delta;
	assign next_dn = {1'b0, dac_code_q} - delta;

	always_comb begin
		code_d = dac_code_q;
		if (lin_jump) begin
			code_d = target;
		end else if (up) begin
			if (cfg_q.log_slew_en && dac_code_q == '0) begin
				code_d = CODE_W'(1);
			end else if (next_up >= {1'b0, target}) begin
				code_d = target;
			end else begin
				code_d = next_up[CODE_W-1:0];
			end
		end else begin
			if (next_dn[CODE_W] || next_dn <= {1'b0, target}) begin
				code_d = target;
			end else begin
				code_d = next_dn[CODE_W-1:0];
			end
		end
	end

	// output code moves one step per interval
	// Code holds between steps and at the target
	always_ff @(posedge clk) begin
		if (reset) begin
			dac_code_q <= '0;
		end else if (step_now) begin
			dac_code_q <= code_d;
		end
	end

	// ==========================================================
	// Status
	// ==========================================================
	// Busy while code differs from target
	// Looks at the next code so busy drops with the landing step
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= step_now ? (code_d != target) : !at_target;
		end
	end

	// ==========================================================
	// Waveform selection decode
	// ==========================================================
	// disable code stops generation
	always_ff @(posedge clk) begin
		if (reset) begin
			fgen_on_q <= 1'b1;
		end else begin
			fgen_on_q <= cfg_q.waveform_select_ch2 != FIELD_DISABLE;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wave_q <= LSR_TRIANGLE;
		end else begin
			case (cfg_q.waveform_select_ch2)
				WSEL_TRIANGLE: wave_q <= LSR_TRIANGLE;
				WSEL_SAWTOOTH: wave_q <= LSR_SAWTOOTH;
				WSEL_INV_SAW: wave_q <= LSR_INV_SAWTOOTH;
				WSEL_SINE: wave_q <= LSR_SINE;
				FIELD_DISABLE: wave_q <= LSR_OFF;
				default: wave_q <= LSR_INVALID;
			endcase
		end
	end

endmodule : lsr_ramp_ch2

// File: shared/lsr_pkg.sv
package lsr_pkg;

	// ==========================================================
	// Configuration word layout
	// ==========================================================
	localparam int CFG_W = 16;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [2:0] FIELD_DISABLE = 3'h7;
	localparam logic [2:0] WSEL_TRIANGLE = 3'h0;
	localparam logic [2:0] WSEL_SAWTOOTH = 3'h1;
	localparam logic [2:0] WSEL_INV_SAW = 3'h2;
	localparam logic [2:0] WSEL_SINE = 3'h4;
	localparam logic [3:0] LIN_NO_SLEW = 4'h0;
	localparam int LOG_SHIFT = 5; // 1/32 = 0.03125 = 3.125 percent
	localparam int CNT_W = 20;

	// Bits 15-13 unused, 12-11 phase, 10-8 waveform, 7 log enable,
	// 6-4 rise (log) or code step (linear), 3-1 fall (log),
	// 3-0 slew rate (linear), bit 0 unused in log mode.
	typedef struct packed {
		logic [2:0] unused;
		logic [1:0] phase_sel;
		logic [2:0] waveform_select_ch2;
		logic log_slew_en;
		logic [2:0] rise_sel;
		logic [2:0] fall_sel;
		logic lsb;
	} lsr_cfg_t;

	typedef enum logic [2:0] {
		LSR_TRIANGLE,
		LSR_SAWTOOTH,
		LSR_INV_SAWTOOTH,
		LSR_SINE,
		LSR_OFF,
		LSR_INVALID
	} lsr_wave_t;

	// ==========================================================
	// Step times in nanoseconds
	// ==========================================================
	localparam int T_4US_NS = 4000;
	localparam int T_8US_NS = 8000;
	localparam int T_12US_NS = 12000;
	localparam int T_18US_NS = 18000;
	localparam int T_27US_NS = 27040;
	localparam int T_40US_NS = 40480;
	localparam int T_60US_NS = 60720;
	localparam int T_91US_NS = 91120;
	localparam int T_136US_NS = 136720;
	localparam int T_239US_NS = 239200;
	localparam int T_418US_NS = 418640;
	localparam int T_732US_NS = 732560;
	localparam int T_1282US_NS = 1282000;
	localparam int T_5127US_NS = 5127920;

	// Logarithmic rise and fall share one table; fall stops at 101 (fall 110 and 111 still decode to 1282 us)
	function automatic int lsr_log_ns(input logic [2:0] sel);
		case (sel)
			3'h0: lsr_log_ns = T_4US_NS;
			3'h1: lsr_log_ns = T_12US_NS;
			3'h2: lsr_log_ns = T_27US_NS;
			3'h3: lsr_log_ns = T_60US_NS;
			3'h4: lsr_log_ns = T_136US_NS;
			3'h5: lsr_log_ns = T_418US_NS;
			default: lsr_log_ns = T_1282US_NS;
		endcase
	endfunction : lsr_log_ns

	// Linear slew table; 1110 taken as the slowest rate
	function automatic int lsr_lin_ns(input logic [3:0] sel);
		case (sel)
			4'h1: lsr_lin_ns = T_4US_NS;
			4'h2: lsr_lin_ns = T_8US_NS;
			4'h3: lsr_lin_ns = T_12US_NS;
			4'h4: lsr_lin_ns = T_18US_NS;
			4'h5: lsr_lin_ns = T_27US_NS;
			4'h6: lsr_lin_ns = T_40US_NS;
			4'h7: lsr_lin_ns = T_60US_NS;
			4'h8: lsr_lin_ns = T_91US_NS;
			4'h9: lsr_lin_ns = T_136US_NS;
			4'ha: lsr_lin_ns = T_239US_NS;
			4'hb: lsr_lin_ns = T_418US_NS;
			4'hc: lsr_lin_ns = T_732US_NS;
			4'hd: lsr_lin_ns = T_1282US_NS;
			default: lsr_lin_ns = T_5127US_NS;
		endcase
	endfunction : lsr_lin_ns

	// Linear code step in LSB
	function automatic logic [5:0] lsr_lin_step(input logic [2:0] sel);
		case (sel)
			3'h0: lsr_lin_step = 6'h01;
			3'h1: lsr_lin_step = 6'h02;
			3'h2: lsr_lin_step = 6'h03;
			3'h3: lsr_lin_step = 6'h04;
			3'h4: lsr_lin_step = 6'h06;
			3'h5: lsr_lin_step = 6'h08;
			3'h6: lsr_lin_step = 6'h10;
			default: lsr_lin_step = 6'h20;
		endcase
	endfunction : lsr_lin_step

endpackage : lsr_pkg

// File: dv/lsr_ramp_ch2_chk.sv
`timescale 1ns/1ns
module lsr_ramp_ch2_chk #(
	parameter int CODE_W = 10
) (
	// Clock, reset and config
	input wire logic clk,
	input wire logic reset,
	input wire logic cfg_wr,
	input wire lsr_pkg::lsr_cfg_t cfg_wdata,
	input wire lsr_pkg::lsr_cfg_t cfg_q,
	// Margins and outputs
	input wire logic [CODE_W-1:0] margin_low,
	input wire logic [CODE_W-1:0] margin_high,
	input wire logic margin_high_pin,
	input wire logic [CODE_W-1:0] dac_code_q,
	input wire logic busy_q,
	input wire lsr_pkg::lsr_wave_t wave_q,
	input wire logic fgen_on_q
);
	import lsr_pkg::*;
	// ==========================================================
	// Step bookkeeping
	logic [CODE_W-1:0] pd_q;
	logic [CODE_W-1:0] st;
	logic lg_q;
	logic [11:0] gap_q;
	// Gap saturates so a long idle spell never wraps
	always_ff @(posedge clk) begin
		pd_q <= dac_code_q;
		lg_q <= cfg_q.log_slew_en;
		if (reset)
			gap_q <= 12'hfff;
		else if (dac_code_q != pd_q)
			gap_q <= 12'h000;
		else if (!(&gap_q))
			gap_q <= gap_q + 12'h001;
	end
	// Geometric step, one LSB at the least
	assign st = (pd_q >> 5) == '0 ? CODE_W'(1) : pd_q >> 5;
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	property p_fgen; fgen_on_q == ($past(cfg_q.waveform_select_ch2) != 3'h7);
	endproperty
	a_fgen: assert property (p_fgen) else $error("gen enable bad");
	property p_saw;
		$past(cfg_q.waveform_select_ch2) == 3'h1 |-> wave_q == LSR_SAWTOOTH;
	endproperty
	a_saw: assert property (p_saw) else $error("sawtooth bad");
	property p_sine;
		$past(cfg_q.waveform_select_ch2) == 3'h4 |-> wave_q == LSR_SINE;
	endproperty
	a_sine: assert property (p_sine) else $error("sine bad");
	property p_up; lg_q && dac_code_q > pd_q |-> dac_code_q - pd_q == st
		|| dac_code_q == margin_high || dac_code_q == margin_low;
	endproperty
	a_up: assert property (p_up) else $error("up step bad");
	property p_dn; lg_q && dac_code_q < pd_q |-> pd_q - dac_code_q == st
		|| dac_code_q == margin_high || dac_code_q == margin_low;
	endproperty
	a_dn: assert property (p_dn) else $error("down step bad");
	property p_zero; lg_q && pd_q == '0 |-> dac_code_q <= CODE_W'(1);
	endproperty
	a_zero: assert property (p_zero) else $error("zero start bad");
	property p_hold; cfg_q.log_slew_en && !busy_q |=> $stable(dac_code_q);
	endproperty
	a_hold: assert property (p_hold) else $error("idle code moved");
	property p_gap; lg_q && dac_code_q != pd_q |-> gap_q >= 12'h003;
	endproperty
	a_gap: assert property (p_gap) else $error("steps too close");
	c_up: cover property (lg_q && dac_code_q > pd_q);
	c_dn: cover property (lg_q && dac_code_q < pd_q);
	c_land: cover property ($fell(busy_q));
endmodule : lsr_ramp_ch2_chk

bind lsr_ramp_ch2 lsr_ramp_ch2_chk #(.CODE_W(CODE_W)) i_chk (.clk(clk),
	.reset(reset), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_q(cfg_q),
	.margin_low(margin_low), .margin_high(margin_high),
	.margin_high_pin(margin_high_pin), .dac_code_q(dac_code_q),
	.busy_q(busy_q), .wave_q(wave_q), .fgen_on_q(fgen_on_q));

// File: dv/lsr_ramp_ch2_tb_top.sv
`timescale 1ns/1ns
module lsr_ramp_ch2_tb_top;
	import lsr_pkg::*;
	// ==========================================================
	// Stimulus and design
	logic clk = 0, reset = 1, cfg_wr = 0, pin = 0, busy, fgen;
	lsr_cfg_t cfg_wdata = '0, cfg_q, w;
	logic [9:0] lo = 0, hi = 0, dac, cur;
	lsr_wave_t wave;
	int mismatches = 0, comparisons = 0, cyc = 0, rnd = 9;
	// Step counts scaled so 4 us is 4 cycles
	lsr_ramp_ch2 #(.CLK_PERIOD_NS(1000)) i_dut (.clk(clk), .reset(reset),
		.cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_q(cfg_q),
		.margin_low(lo), .margin_high(hi), .margin_high_pin(pin),
		.dac_code_q(dac), .busy_q(busy), .wave_q(wave), .fgen_on_q(fgen));
	initial forever #10 clk = ~clk;
	// Hang guard, well above the slowest sweep
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			mismatches++;
			end_sim();
		end
	end
	function automatic int lfsr();
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		return rnd;
	endfunction : lfsr
	// Expected next code, clamped onto the target
	function automatic logic [9:0] nxt(logic [9:0] c, logic [9:0] t);
		logic [9:0] s;
		s = (c >> 5) == 0 ? 10'h001 : c >> 5;
		if (c < t)
			return (t - c < s) ? t : c + s;
		return (c - t < s) ? t : c - s;
	endfunction : nxt
	function automatic int per(logic [2:0] s);
		int ns[7] = '{4000, 12000, 27040, 60720, 136720, 418640, 1282000};
		return (ns[s] + 999) / 1000;
	endfunction : per
	function automatic lsr_wave_t ew(int i);
		case (i)
			0: return LSR_TRIANGLE;
			1: return LSR_SAWTOOTH;
			2: return LSR_INV_SAWTOOTH;
			4: return LSR_SINE;
			7: return LSR_OFF;
			default: return LSR_INVALID;
		endcase
	endfunction : ew
	// ==========================================================
	// Tasks; inputs move 1 ns after the edge
	task automatic tick(int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t %s %h/%h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wr(lsr_cfg_t v);
		cfg_wdata = v;
		cfg_wr = 1;
		tick();
		cfg_wr = 0;
		tick();
		chk(cfg_q, v, "cfg");
	endtask : wr
	// First step waits on the pin synchroniser, so only later gaps timed
	task automatic ramp(logic up);
		int n, p;
		logic [9:0] t;
		t = up ? hi : lo;
		p = per(dac < t ? cfg_q.rise_sel : cfg_q.fall_sel);
		pin = up;
		cur = dac;
		for (int k = 0; cur != t; k++) begin
			n = 0;
			while (dac == cur && n < 2000) begin
				tick();
				n++;
			end
			chk(dac, nxt(cur, t), "step");
			chk(busy, dac != t, "busy");
			if (k > 0) chk(n, p, "gap");
			cur = nxt(cur, t);
		end
		tick(5);
		chk({dac, busy}, {t, 1'b0}, "hold");
	endtask : ramp
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// ==========================================================
	initial begin
		tick(20);
		reset = 0;
		chk({cfg_q, dac, busy, wave, fgen},
			{16'h0000, 10'h000, 1'b0, LSR_TRIANGLE, 1'b1}, "reset");
		for (int i = 0; i < 8; i++) begin
			w = '0;
			w.waveform_select_ch2 = 3'(i);
			wr(w);
			chk({wave, fgen}, {ew(i), i != 7}, "wave");
		end
		$display("waveform test done");
		for (int s = 0; s < 7; s++) begin
			w = '0;
			w.log_slew_en = 1;
			wr(w);
			lo = s == 0 ? 10'h000 : 10'(lfsr() % 1000);
			hi = lo + 10'(lfsr() % 8 + 1);
			ramp(0);
			w.rise_sel = 3'(s);
			w.fall_sel = s > 5 ? 3'h5 : 3'(s);
			w.waveform_select_ch2 = 3'(lfsr());
			wr(w);
			ramp(1);
			ramp(0);
		end
		$display("log sweep done");
		w = '0;
		w.rise_sel = 3'h6;
		w.lsb = 1;
		wr(w);
		hi = 10'h3f0;
		pin = 1;
		cur = dac;
		for (int n = 0; n < 20 && dac == cur; n++) tick();
		chk(dac, (hi - cur < 16) ? hi : cur + 10'h010, "lin");
		$display("linear test done");
		end_sim();
	end
endmodule : lsr_ramp_ch2_tb_top
